// ==== hw/nsi_regs.svh ====
// constants for the node identity and status indicator block
`ifndef NSI_REGS_SVH
`define NSI_REGS_SVH
// ==========================================================================
// node identifier
// ==========================================================================
`define NSI_ID_W 8
`define NSI_ID_ALL_ON 8'hFF
`define NSI_ID_MIN 8'h01
`define NSI_ALIAS_W 16
`define NSI_ALIAS_ZERO 16'h0000
// ==========================================================================
// timebase: indicator tick of 50 ms at 10 MHz
// ==========================================================================
`define NSI_CLK_HZ 10000000
`define NSI_TICK_MS 50
`define NSI_TICK_CYC ((`NSI_CLK_HZ / 1000) * `NSI_TICK_MS)
`define NSI_TICK_CNT_W 19
`define NSI_SLOT_W 4
`define NSI_SLOT_LAST 4'h9
// flicker: 10 Hz toggle
`define NSI_FLICK_MS 50
`define NSI_FLICK_CYC ((`NSI_CLK_HZ / 1000) * `NSI_FLICK_MS)
// ==========================================================================
// pattern masks: 10 slots of 50 ms... slot index 0..9 within a 500 ms frame
// blinking 200 ms on / 200 ms off toggles on each wrap of a separate 4-phase count instead
// ==========================================================================
`define NSI_SFLASH_MASK 10'h00F
`define NSI_DFLASH_MASK 10'h0F3
`define NSI_SFLASH_MASK_SH 10'h1E0
`define NSI_DFLASH_MASK_SH 10'h3CF
`define NSI_SLOTS 10
`endif

// ==== hw/nsi_pkg.sv ====
// types shared by the node identity and status indicator block
package nsi_pkg;
    // slave state machine encoding as delivered by the comms core
    typedef enum logic [1:0] {
        NSI_ST_INIT = 2'b00,
        NSI_ST_PREOP = 2'b01,
        NSI_ST_SAFEOP = 2'b10,
        NSI_ST_OP = 2'b11
    } nsi_slave_e;

    // indicator pattern
    typedef enum logic [2:0] {
        NSI_PAT_OFF = 3'b000,
        NSI_PAT_ON = 3'b001,
        NSI_PAT_BLINK = 3'b010,
        NSI_PAT_SFLASH = 3'b011,
        NSI_PAT_DFLASH = 3'b100,
        NSI_PAT_FLICK = 3'b101
    } nsi_pat_e;

    // error conditions reported by the application
    typedef struct packed {
        logic critical;  // controller or comms failure
        logic watchdog;  // process data or bus watchdog timeout
        logic local_err; // autonomous state change
        logic bad_cfg;   // invalid configuration
        logic boot_err;  // booting error
    } nsi_err_s;

    // port activity
    typedef struct packed {
        logic link;      // physical link up
        logic activity;  // frame seen
    } nsi_port_s;
endpackage

// ==== hw/nsi_status.sv ====
// node identity capture and run/error/link indicator driver
`timescale 1ns/1ps
`include "nsi_regs.svh"
module nsi_status (
    input wire logic mclk,                            // 10 MHz drive clock
    input wire logic arst_n,                          // async reset, active low
    input wire logic [`NSI_ID_W-1:0] config_switch_bank, // switch pins, closed pulls low
    input wire logic setup_valid,                     // stored setup is valid
    input wire logic [`NSI_ID_W-1:0] sw_node_id,      // software-assigned identifier
    input wire logic node_addr_mode,                  // node addressing in use
    input wire logic init_done,                       // firmware init finished
    input wire nsi_pkg::nsi_slave_e slave_state,      // slave state machine
    input wire nsi_pkg::nsi_err_s err_in,             // error conditions
    input wire nsi_pkg::nsi_port_s out_port,          // out-port phy status
    output logic [`NSI_ID_W-1:0] node_identifier,     // captured identifier
    output logic id_valid,                            // identifier captured
    output logic [`NSI_ALIAS_W-1:0] station_alias,    // configured station alias value
    output logic alias_we,                            // one-cycle alias write strobe
    output logic al_status_err,                       // error indicator bit for status
    output logic led_run,                             // green run led, high lit
    output logic led_err,                             // red error led, high lit
    output logic led_link                             // green out-port link/activity
);
    import nsi_pkg::*;

    // ======================================================================
    // input synchronisers
    // ======================================================================
    logic [`NSI_ID_W-1:0] sw_meta; // first stage, read only by sw_sync
    logic [`NSI_ID_W-1:0] sw_sync; // switch bank in clock domain
    logic [1:0] port_meta;         // first stage of link/activity pins
    logic [1:0] port_sync;         // link/activity in clock domain

    // two flops on every pin input
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sw_meta <= '0;
            sw_sync <= '0;
            port_meta <= 2'h0;
            port_sync <= 2'h0;
        end else begin
            sw_meta <= config_switch_bank;
            sw_sync <= sw_meta;
            port_meta <= out_port;
            port_sync <= port_meta;
        end
    end

    // ======================================================================
    // node identifier capture
    // ======================================================================
    logic [1:0] cap_wait;  // lets the synchroniser fill after reset
    logic captured;        // switches already sampled
    logic [`NSI_ID_W-1:0] hw_id; // switch word, open = 1
    logic [`NSI_ID_W-1:0] next_id;

    // an open switch pulls high, so the pin level is the bit itself
    assign hw_id = sw_sync;

    // identifier choice; 0 cannot come from switches, all-closed maps to 255
    always_comb begin
        if (hw_id == '0) begin
            next_id = `NSI_ID_ALL_ON;
        end else begin
            next_id = hw_id;
        end
        // software value only when setup is valid and in range
        if (setup_valid && sw_node_id >= `NSI_ID_MIN) begin
            next_id = sw_node_id;
        end
        if (!setup_valid) begin
            next_id = (hw_id == '0) ? `NSI_ID_ALL_ON : hw_id;
        end
    end

    // sample once; the pins are ignored until the next reset
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cap_wait <= 2'h0;
            captured <= 1'b0;
            node_identifier <= `NSI_ID_ALL_ON;
            id_valid <= 1'b0;
        end else if (!captured) begin
            cap_wait <= cap_wait + 2'h1;
            if (cap_wait == 2'h3) begin
                captured <= 1'b1;
                node_identifier <= next_id;
                id_valid <= 1'b1;
            end
        end
    end

    // ======================================================================
    // station alias load
    // ======================================================================
    logic alias_done; // alias written once per power-up

    // single write after capture when node addressing is selected
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            alias_done <= 1'b0;
            alias_we <= 1'b0;
            station_alias <= `NSI_ALIAS_ZERO;
        end else begin
            alias_we <= 1'b0;
            if (id_valid && node_addr_mode && !alias_done) begin
                alias_done <= 1'b1;
                alias_we <= 1'b1;
                if (node_identifier == `NSI_ID_ALL_ON) begin
                    station_alias <= `NSI_ALIAS_ZERO;
                end else begin
                    station_alias <= {{(`NSI_ALIAS_W-`NSI_ID_W){1'b0}}, node_identifier};
                end
            end
        end
    end

    // ======================================================================
    // shared timebase: 50 ms ticks, 10 slots per 500 ms frame
    // ======================================================================
    logic [`NSI_TICK_CNT_W-1:0] tick_cnt; // divider
    logic tick;                           // one-cycle enable every 50 ms
    logic [`NSI_SLOT_W-1:0] slot;         // slot within frame
    logic [1:0] blink_ph;                 // 4 ticks -> 200 ms halves
    logic blink_lvl;                      // 200 ms on / 200 ms off
    logic flick_lvl;                      // 50 ms on / 50 ms off

    // one divider feeds every pattern so they stay aligned
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else if (tick_cnt == `NSI_TICK_CNT_W'(`NSI_TICK_CYC - 1)) begin
            tick_cnt <= '0;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + `NSI_TICK_CNT_W'(1);
            tick <= 1'b0;
        end
    end

    // slot, blink and flicker phases advance on the tick
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            slot <= 4'h0;
            blink_ph <= 2'h0;
            blink_lvl <= 1'b0;
            flick_lvl <= 1'b0;
        end else if (tick) begin
            slot <= (slot == `NSI_SLOT_LAST) ? 4'h0 : slot + 4'h1;
            flick_lvl <= ~flick_lvl;
            blink_ph <= blink_ph + 2'h1;
            if (blink_ph == 2'h3) begin
                blink_lvl <= ~blink_lvl;
            end
        end
    end

    // ======================================================================
    // pattern decode
    // ======================================================================
    nsi_pat_e run_pat; // chosen run pattern
    nsi_pat_e err_pat; // chosen error pattern
    logic run_lvl;
    logic err_lvl;
    logic any_err;

    assign any_err = |err_in;

    // run pattern from slave state; dark until init and on any error
    always_comb begin
        unique case (slave_state)
            NSI_ST_INIT: run_pat = NSI_PAT_OFF;
            NSI_ST_PREOP: run_pat = NSI_PAT_BLINK;
            NSI_ST_SAFEOP: run_pat = NSI_PAT_SFLASH;
            NSI_ST_OP: run_pat = NSI_PAT_ON;
        endcase
        if (!init_done || any_err) begin
            run_pat = NSI_PAT_OFF;
        end
    end

    // severity order, first match wins
    always_comb begin
        if (err_in.critical) begin
            err_pat = NSI_PAT_ON;
        end else if (err_in.watchdog) begin
            err_pat = NSI_PAT_DFLASH;
        end else if (err_in.local_err) begin
            err_pat = NSI_PAT_SFLASH;
        end else if (err_in.bad_cfg) begin
            err_pat = NSI_PAT_BLINK;
        end else if (err_in.boot_err) begin
            err_pat = NSI_PAT_FLICK;
        end else begin
            err_pat = NSI_PAT_OFF;
        end
    end

    // pattern level; run uses the half-frame shifted masks and inverted blink
    function automatic logic pat_level(input nsi_pat_e p, input logic shifted,
                                       input logic [`NSI_SLOT_W-1:0] s, input logic bl,
                                       input logic fl);
        logic [`NSI_SLOTS-1:0] sf;
        logic [`NSI_SLOTS-1:0] df;
        sf = shifted ? `NSI_SFLASH_MASK_SH : `NSI_SFLASH_MASK;
        df = shifted ? `NSI_DFLASH_MASK_SH : `NSI_DFLASH_MASK;
        unique case (p)
            NSI_PAT_ON: pat_level = 1'b1;
            NSI_PAT_BLINK: pat_level = bl ^ shifted;
            NSI_PAT_SFLASH: pat_level = ~sf[s];
            NSI_PAT_DFLASH: pat_level = ~df[s];
            NSI_PAT_FLICK: pat_level = fl ^ shifted;
            default: pat_level = 1'b0;
        endcase
    endfunction

    // masks mark off-slots: the unshifted single flash is lit in slots 4-9, i.e. lit where
    // mask bit clear; the shifted single flash mask moves the lit window half a frame
    assign run_lvl = pat_level(run_pat, 1'b1, slot, blink_lvl, flick_lvl);
    assign err_lvl = pat_level(err_pat, 1'b0, slot, blink_lvl, flick_lvl);

    // ======================================================================
    // outputs, all registered
    // ======================================================================
    logic act_stretch; // activity flicker window
    logic [1:0] act_hold;

    // activity stretched to a visible flicker; steady when link only
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            act_hold <= 2'h0;
            act_stretch <= 1'b0;
        end else begin
            if (port_sync[0]) begin
                act_hold <= 2'h3;
            end else if (tick && act_hold != 2'h0) begin
                act_hold <= act_hold - 2'h1;
            end
            act_stretch <= (act_hold != 2'h0);
        end
    end

    // indicator and status flops
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            led_run <= 1'b0;
            led_err <= 1'b0;
            led_link <= 1'b0;
            al_status_err <= 1'b0;
        end else begin
            led_run <= run_lvl;
            led_err <= err_lvl;
            // link lit; blinks with flicker while traffic passes
            led_link <= port_sync[1] & ~(act_stretch & flick_lvl);
            al_status_err <= err_in.local_err | err_in.boot_err;
        end
    end
endmodule

// ==== bench/nsi_status_monitor.sv ====
// concurrent checks on the node identity and indicator block ports
`timescale 1ns/1ps
`include "nsi_regs.svh"
module nsi_status_monitor (
    input wire logic mclk,                          // drive clock
    input wire logic arst_n,                        // async reset, active low
    input wire logic node_addr_mode,                // node addressing in use
    input wire logic init_done,                     // firmware init finished
    input wire nsi_pkg::nsi_slave_e slave_state,    // slave state
    input wire nsi_pkg::nsi_err_s err_in,           // error conditions
    input wire nsi_pkg::nsi_port_s out_port,        // out-port phy status
    input wire logic [`NSI_ID_W-1:0] node_identifier, // captured identifier
    input wire logic id_valid,                      // identifier captured
    input wire logic [`NSI_ALIAS_W-1:0] station_alias, // alias value
    input wire logic alias_we,                      // alias write strobe
    input wire logic al_status_err,                 // status error bit
    input wire logic led_run,                       // run led
    input wire logic led_err,                       // error led
    input wire logic led_link                       // link led
);
    import nsi_pkg::*;
    // ==========================================================
    // helper history
    // ==========================================================
    logic [1:0] n_alias; // alias strobes since reset, saturating
    logic [1:0] crit_h, dirty_h, clean_h, run_h, flag_h; // two-deep input history
    logic [20:0] idle_cnt; // cycles of quiet link, saturating past the activity stretch
    // activity stretch lasts up to three 50 ms ticks, so only a long quiet link must show steady
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            idle_cnt <= 21'h000000;
        end else if (!(out_port.link && !out_port.activity)) begin
            idle_cnt <= 21'h000000;
        end else if (idle_cnt != 21'h1E8480) begin
            idle_cnt <= idle_cnt + 21'h000001;
        end
    end
    // count strobes so a second one in the same power cycle shows
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            n_alias <= 2'h0;
        end else if (alias_we && n_alias != 2'h3) begin
            n_alias <= n_alias + 2'h1;
        end
    end
    // two samples deep so the checks hold for one or two stages of latency
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            crit_h <= 2'h0;
            dirty_h <= 2'h0;
            clean_h <= 2'h0;
            run_h <= 2'h0;
            flag_h <= 2'h0;
        end else begin
            crit_h <= {crit_h[0], err_in.critical};
            dirty_h <= {dirty_h[0], |err_in};
            clean_h <= {clean_h[0], err_in == 5'h00};
            run_h <= {run_h[0], init_done && slave_state == NSI_ST_OP && err_in == 5'h00};
            flag_h <= {flag_h[0], err_in.local_err | err_in.boot_err};
        end
    end
    // ==========================================================
    // assertions
    // ==========================================================
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    a_id_held_stable: assert property (id_valid && $past(id_valid) |-> $stable(node_identifier))
        else $error("node identifier changed after capture");
    a_id_not_zero: assert property (id_valid |-> node_identifier != 8'h00)
        else $error("node identifier out of range");
    a_alias_copies_id: assert property (alias_we && node_identifier != 8'hFF |->
        station_alias == {8'h00, node_identifier})
        else $error("alias differs from identifier");
    a_alias_ff_zero: assert property (alias_we && node_identifier == 8'hFF |-> station_alias == 16'h0000)
        else $error("alias not zero for identifier 255");
    a_alias_needs_mode: assert property (alias_we |-> id_valid && $past(node_addr_mode))
        else $error("alias written without node addressing");
    a_alias_only_once: assert property (n_alias < 2'h2)
        else $error("alias written twice in one power cycle");
    a_crit_err_on: assert property (crit_h == 2'h3 |-> led_err)
        else $error("error led dark during critical failure");
    a_run_dark_err: assert property (dirty_h == 2'h3 |-> !led_run)
        else $error("run led lit with an error present");
    a_run_on_op: assert property (run_h == 2'h3 |-> led_run)
        else $error("run led dark in operational state");
    a_err_dark_clean: assert property (clean_h == 2'h3 |-> !led_err)
        else $error("error led lit with no error");
    a_status_bit_follows: assert property (flag_h[0] == flag_h[1] |-> al_status_err == flag_h[0])
        else $error("status error bit wrong");
    a_link_dark_down: assert property ((!out_port.link) [*5] |-> !led_link)
        else $error("link led lit without link");
    a_link_lit_up: assert property (idle_cnt == 21'h1E8480 |-> led_link)
        else $error("link led dark with idle link");
    c_alias_zero: cover property (alias_we && node_identifier == 8'hFF);
    c_err_lit: cover property (led_err && !led_run);
    c_link_lit: cover property (led_link);
endmodule

// ==== bench/nsi_port_model.sv ====
// out-port phy stand-in: reports link state and frame activity
`timescale 1ns/1ps
module nsi_port_model (
    input wire logic mclk,              // drive clock
    input wire logic arst_n,            // async reset, active low
    input wire logic link_up,           // cable plugged and trained
    input wire logic traffic,           // frames passing
    output nsi_pkg::nsi_port_s port_st  // status to the block
);
    import nsi_pkg::*;
    // activity pulses per frame and never shows without a link
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            port_st <= 2'h0;
        end else begin
            port_st.link <= link_up;
            port_st.activity <= link_up && traffic && !port_st.activity;
        end
    end
endmodule

// ==== bench/node_id_and_status_indicators_test.sv ====
// self-checking bench for the node identity and status indicator block
`timescale 1ns/1ps
`include "nsi_regs.svh"
module node_id_and_status_indicators_test;
    import nsi_pkg::*;
    logic mclk = 1'b0, arst_n = 1'b0, setup_valid = 1'b0, addr_mode = 1'b0, init_done = 1'b0;
    logic link_up = 1'b0, traffic = 1'b0; // far-side controls
    logic [7:0] sw_bank = 8'h00, sw_id = 8'h00, node_identifier; // switch pins and ids
    nsi_slave_e slave_state = NSI_ST_INIT; // slave state input
    nsi_err_s err_in = 5'h00; // error conditions
    nsi_port_s port_st; // model to block
    logic [15:0] station_alias; // alias value out
    logic id_valid, alias_we, al_status_err, led_run, led_err, led_link; // block outputs
    int n_mismatch = 0, comparisons = 0;
    logic [17:0] cases [6] = '{18'h00332, 18'h3FC02, 18'h00402, 18'h168CF, 18'h20002, 18'h297FF};
    logic [31:0] r; // random draw
    always #50 mclk = ~mclk;
    nsi_status dut_u (.mclk(mclk), .arst_n(arst_n), .config_switch_bank(sw_bank),
        .setup_valid(setup_valid), .sw_node_id(sw_id), .node_addr_mode(addr_mode),
        .init_done(init_done), .slave_state(slave_state), .err_in(err_in), .out_port(port_st),
        .node_identifier(node_identifier), .id_valid(id_valid), .station_alias(station_alias),
        .alias_we(alias_we), .al_status_err(al_status_err), .led_run(led_run), .led_err(led_err),
        .led_link(led_link));
    nsi_port_model pm_u (.mclk(mclk), .arst_n(arst_n), .link_up(link_up), .traffic(traffic),
        .port_st(port_st));
    // ==========================================================
    // shared tasks
    // ==========================================================
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #10;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done;
        if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // expected identifier: software id only from a valid setup, all closed gives 255
    function automatic logic [7:0] exp_id(input logic [17:0] c);
        return (c[1] && c[9:2] != 8'h00) ? c[9:2] : ((c[17:10] == 8'h00) ? 8'hFF : c[17:10]);
    endfunction
    // power cycle with entry {switches, soft id, setup valid, addressing}
    task automatic power_up(input logic [17:0] c);
        int k;
        logic [7:0] id;
        id = exp_id(c);
        arst_n = 1'b0;
        {sw_bank, sw_id, setup_valid, addr_mode} = c;
        step(4);
        arst_n = 1'b1;
        k = 0;
        while (id_valid !== 1'b1 && k < 12) begin
            step(1);
            k++;
        end
        if (k == 12) begin
            n_mismatch++;
            test_done();
        end
        check("node_identifier", {8'h00, id}, {8'h00, node_identifier});
        k = 0;
        while (alias_we !== 1'b1 && k < 4) begin
            step(1);
            k++;
        end
        check("alias_we", {15'h0000, c[0]}, {15'h0000, alias_we});
        if (c[0]) check("station_alias", (id == 8'hFF) ? 16'h0000 : {8'h00, id}, station_alias);
        sw_bank = ~sw_bank; // switches moved after capture
        step(6);
        check("node_identifier held", {8'h00, id}, {8'h00, node_identifier});
    endtask
    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        r = $urandom(10);
        for (int i = 0; i < 12; i++) begin
            r = $urandom;
            power_up((i < 6) ? cases[i] : r[17:0]);
        end
        // run indicator against slave state and init
        slave_state = NSI_ST_OP;
        step(4);
        check("led_run before init", 16'h0000, {15'h0000, led_run});
        check("led_err clean", 16'h0000, {15'h0000, led_err});
        init_done = 1'b1;
        step(4);
        check("led_run op", 16'h0001, {15'h0000, led_run});
        slave_state = NSI_ST_INIT;
        step(4);
        check("led_run init", 16'h0000, {15'h0000, led_run});
        slave_state = NSI_ST_PREOP;
        step(4);
        check("led_run preop", 16'h0001, {15'h0000, led_run});
        slave_state = NSI_ST_SAFEOP;
        step(4);
        check("led_run safeop", 16'h0001, {15'h0000, led_run});
        slave_state = NSI_ST_OP;
        err_in = 5'h18; // critical with watchdog
        step(3);
        for (int i = 0; i < 20; i++) begin
            step(1);
            check("led_err critical", 16'h0001, {15'h0000, led_err});
            check("led_run error", 16'h0000, {15'h0000, led_run});
        end
        // each error condition alone, then random mixes
        for (int b = 0; b < 5; b++) begin
            err_in = 5'h01 << b;
            step(4);
            check("al_status_err", {15'h0000, b == 0 || b == 2}, {15'h0000, al_status_err});
            check("led_run error", 16'h0000, {15'h0000, led_run});
            check("led_err first slot", {15'h0000, b == 4}, {15'h0000, led_err});
        end
        for (int i = 0; i < 20; i++) begin
            r = $urandom;
            err_in = r[4:0];
            step(3);
            check("al_status_err mix", {15'h0000, r[2] | r[0]}, {15'h0000, al_status_err});
        end
        err_in = 5'h00;
        // link indicator through the port model
        link_up = 1'b1;
        step(6);
        check("led_link up", 16'h0001, {15'h0000, led_link});
        traffic = 1'b1;
        step(20);
        link_up = 1'b0;
        step(6);
        check("led_link down", 16'h0000, {15'h0000, led_link});
        test_done();
    end
endmodule
bind nsi_status nsi_status_monitor mon_u (.mclk(mclk), .arst_n(arst_n), .node_addr_mode(node_addr_mode),
    .init_done(init_done), .slave_state(slave_state), .err_in(err_in), .out_port(out_port),
    .node_identifier(node_identifier), .id_valid(id_valid), .station_alias(station_alias),
    .alias_we(alias_we), .al_status_err(al_status_err), .led_run(led_run), .led_err(led_err),
    .led_link(led_link));
